// File: fhi_pkg.sv
package fhi_pkg;

  // ****************************************
  // apb register map
  // ****************************************
  localparam logic [11:0] FHI_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] FHI_ADDR_STAT   = 12'h004;
  localparam logic [11:0] FHI_ADDR_DLOCK  = 12'h008;
  localparam logic [11:0] FHI_ADDR_SLOCK  = 12'h00c;
  localparam int          FHI_CTRL_FAST   = 0;
  localparam int          FHI_CTRL_LEN_LO = 4;
  localparam int          FHI_CTRL_STR_LO = 8;
  localparam logic        FHI_FAST_RST    = 1'h0;
  localparam logic [2:0]  FHI_LEN_RST     = 3'h0;
  localparam logic [1:0]  FHI_STRIDE_RST  = 2'h0;
  localparam int          FHI_STAT_CC_LO  = 0;
  localparam int          FHI_STAT_ISS    = 4;
  localparam int          FHI_STAT_CMP    = 5;
  localparam int          FHI_STAT_LDM    = 6;
  localparam int          FHI_STAT_AR     = 7;
  localparam int          FHI_STAT_VS     = 8;

  // ****************************************
  // field encodings and timing
  // ****************************************
  localparam logic [1:0]  FHI_STRIDE_ONE  = 2'h0;
  localparam logic [1:0]  FHI_STRIDE_TWO  = 2'h3;
  localparam logic [3:0]  FHI_FAST_SP_THR = 4'h4;
  localparam logic [3:0]  FHI_FAST_DP_THR = 4'h2;
  localparam logic [2:0]  FHI_CMP_CC_LAT  = 3'h4;
  localparam logic [2:0]  FHI_LDM_WR_LAT  = 3'h4;
  localparam logic [5:0]  FHI_LDM_PER_W   = 6'h2;
  localparam logic [4:0]  FHI_ARITH_WB    = 5'h8;
  localparam logic [1:0]  FHI_CLR_OFF_ONE = 2'h1;
  localparam logic [1:0]  FHI_CLR_OFF_TWO = 2'h2;

  typedef enum logic [2:0] {
    FHI_OP_NOP  = 3'h0,
    FHI_OP_ADD  = 3'h1,
    FHI_OP_MUL  = 3'h2,
    FHI_OP_MAC  = 3'h3,
    FHI_OP_CMP  = 3'h4,
    FHI_OP_XFER = 3'h5,
    FHI_OP_LDM  = 3'h6
  } fhi_op_t;

  typedef enum logic [1:0] {
    FHI_LDM_IDLE  = 2'b00,
    FHI_LDM_PIPE  = 2'b01,
    FHI_LDM_WRITE = 2'b11
  } fhi_ldm_t;

endpackage

// File: fhi_sb_if.sv
`timescale 1ns/1ps
interface fhi_sb_if;
  logic [31:0] set_dst;
  logic [31:0] clr_dst;
  logic [31:0] set_src;
  logic [31:0] clr_src;
  logic [31:0] dst_lock;
  logic [31:0] src_lock;
  modport ctl (output set_dst, clr_dst, set_src, clr_src, input dst_lock, src_lock);
  modport sb  (input set_dst, clr_dst, set_src, clr_src, output dst_lock, src_lock);
endinterface

// File: fhi_scoreboard.sv
`timescale 1ns/1ps
module fhi_scoreboard
  import fhi_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // lock traffic
  fhi_sb_if.sb     sb
);

  typedef struct packed {
    logic [31:0] dst;
    logic [31:0] src;
  } fhi_sb_st_t;

  fhi_sb_st_t st;
  fhi_sb_st_t next_st;

  // ****************************************
  // lock bits, set wins over clear
  // ****************************************
  always_comb begin
    next_st.dst = (st.dst & ~sb.clr_dst) | sb.set_dst;
    next_st.src = (st.src & ~sb.clr_src) | sb.set_src;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign sb.dst_lock = st.dst;
  assign sb.src_lock = st.src;

  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (sb.set_dst != 32'h0) |=> ((st.dst & $past(sb.set_dst)) == $past(sb.set_dst)))
    else $error("lock set lost against clear");

endmodule

// File: fhi_interlock.sv
// Function
// - status transfer waits in decode after compare
// - condition codes reach core two cycles later
// - add waits for load multiple final transfer
// - vector add waits for the load transfers writing its registers, not the whole load
// - length field b011 means four iterations
// - stride field b00 means stride one
// - add after multiply held seven cycles
// - load multiple waits for source lock release
// - fast single locks only beyond four iterations
// - fast double locks only beyond two iterations
// - fast mode never locks scalar sources
// - fast mode frees overlapping load four cycles
// - full mode locks all vector sources
// - full mode releases sources per execute
`timescale 1ns/1ps
module fhi_interlock
  import fhi_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // decode from core
  input  wire logic        dec_valid,
  input  wire logic [2:0]  dec_op,
  input  wire logic [4:0]  dec_dst,
  input  wire logic [4:0]  dec_src_a,
  input  wire logic [4:0]  dec_src_b,
  input  wire logic [5:0]  dec_count,
  input  wire logic        dec_dp,
  output logic             dec_ready,
  // issue status
  output logic             issue_fire,
  output logic             fwd_hit,
  // condition codes
  input  wire logic [3:0]  cmp_result,
  output logic             cc_valid,
  output logic      [3:0]  cc_out
);

  typedef struct packed {
    logic        fast;
    logic [2:0]  len;
    logic [1:0]  stride;
    logic        iss_valid;
    fhi_op_t     iss_op;
    logic [4:0]  iss_dst;
    logic [4:0]  iss_a;
    logic [4:0]  iss_b;
    logic [5:0]  iss_cnt;
    logic        iss_dp;
    logic [2:0]  cmp_cnt;
    logic [3:0]  fp_status_control_reg_cc;
    logic        cc_valid;
    logic [3:0]  cc_out;
    fhi_ldm_t    ldm_st;
    logic [2:0]  ldm_cnt;
    logic [4:0]  ldm_next;
    logic [5:0]  ldm_left;
    logic        ar_busy;
    logic [4:0]  ar_cnt;
    logic [4:0]  ar_dst;
    logic [3:0]  ar_n;
    logic        vs_active;
    logic [4:0]  vs_a;
    logic [4:0]  vs_b;
    logic        vs_step2;
    logic [3:0]  vs_first;
    logic [3:0]  vs_n;
    logic [1:0]  vs_off;
    logic [3:0]  vs_cnt;
    logic [31:0] prdata;
    logic        pslverr;
  } fhi_st_t;

  fhi_st_t     st;
  fhi_st_t     next_st;
  fhi_sb_if    sbi ();
  logic [3:0]  n_iter;
  logic        step2;
  logic [31:0] src_need;
  logic [31:0] dst_need;
  logic [31:0] dst_eff;
  logic        hazard;
  logic        busy;
  logic        is_arith;
  logic        lock_src;
  logic [3:0]  lock_first;
  logic        xfer_ok;
  logic [3:0]  vs_iter;
  logic        setup;

  // ****************************************
  // register masks
  // ****************************************
  function automatic logic [31:0] vec_mask(input logic [4:0] base, input logic [3:0] n,
                                           input logic [3:0] first, input logic stp2);
    logic [31:0] m;
    logic [2:0]  o;
    m = 32'h0;
    for (int k = 0; k < 8; k++) begin
      if (4'(k) >= first && 4'(k) < n) begin
        o = base[2:0] + (stp2 ? 3'(k * 2) : 3'(k));
        m[{base[4:3], o}] = 1'b1;
      end
    end
    return m;
  endfunction

  function automatic logic [31:0] range_mask(input logic [4:0] base, input logic [5:0] cnt);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 32; i++) begin
      m[i] = (7'(i) >= {2'b00, base}) && (7'(i) < ({2'b00, base} + {1'b0, cnt}));
    end
    return m;
  endfunction

  fhi_scoreboard u_sb (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .sb      (sbi.sb)
  );

  // ****************************************
  // field decode
  // ****************************************
  assign n_iter = {1'b0, st.len} + 4'h1;
  assign step2  = (st.stride == FHI_STRIDE_TWO);

  // ****************************************
  // lock release
  // ****************************************
  always_comb begin
    sbi.clr_dst = 32'h0;
    sbi.clr_src = 32'h0;
    vs_iter     = st.vs_cnt - {2'b00, st.vs_off} + st.vs_first;
    if (st.ldm_st == FHI_LDM_WRITE) begin
      sbi.clr_dst = range_mask(st.ldm_next, (st.ldm_left < FHI_LDM_PER_W) ?
                               st.ldm_left : FHI_LDM_PER_W);
    end
    if (st.ar_busy && st.ar_cnt == 5'h1) begin
      sbi.clr_dst = sbi.clr_dst | vec_mask(st.ar_dst, st.ar_n, 4'h0, 1'b0);
    end
    if (st.vs_active && st.vs_cnt >= {2'b00, st.vs_off}) begin
      sbi.clr_src = vec_mask(st.vs_a, vs_iter + 4'h1, vs_iter, st.vs_step2)
                  | vec_mask(st.vs_b, vs_iter + 4'h1, vs_iter, st.vs_step2);
    end
  end

  // ****************************************
  // issue check
  // ****************************************
  always_comb begin
    is_arith = st.iss_op inside {FHI_OP_ADD, FHI_OP_MUL, FHI_OP_MAC};
    src_need = 32'h0;
    dst_need = 32'h0;
    if (is_arith) begin
      src_need = vec_mask(st.iss_a, n_iter, 4'h0, step2) | vec_mask(st.iss_b, n_iter, 4'h0, step2);
      dst_need = vec_mask(st.iss_dst, n_iter, 4'h0, step2);
    end else if (st.iss_op == FHI_OP_CMP) begin
      src_need = vec_mask(st.iss_a, 4'h1, 4'h0, 1'b0) | vec_mask(st.iss_b, 4'h1, 4'h0, 1'b0);
    end else if (st.iss_op == FHI_OP_LDM) begin
      dst_need = range_mask(st.iss_dst, st.iss_cnt);
    end
    dst_eff = sbi.dst_lock & ~sbi.clr_dst;
    hazard  = |(src_need & dst_eff)
            | |(dst_need & (dst_eff | sbi.src_lock));
    lock_first = st.iss_dp ? FHI_FAST_DP_THR : FHI_FAST_SP_THR;
    if (!st.fast) begin
      lock_src = is_arith;
    end else begin
      lock_src = (st.iss_op inside {FHI_OP_MUL, FHI_OP_MAC})
               && n_iter > lock_first;
    end
    busy = (st.iss_op == FHI_OP_LDM && st.ldm_st != FHI_LDM_IDLE)
         | (is_arith && st.ar_busy && st.ar_cnt != 5'h1)
         | (lock_src && st.vs_active);
    issue_fire = ce && st.iss_valid && !hazard && !busy;
    fwd_hit    = issue_fire && |(src_need & sbi.dst_lock & sbi.clr_dst);
    sbi.set_dst = issue_fire ? dst_need : 32'h0;
    sbi.set_src = 32'h0;
    if (issue_fire && lock_src) begin
      sbi.set_src = vec_mask(st.iss_a, n_iter, st.fast ? lock_first : 4'h0, step2)
                  | vec_mask(st.iss_b, n_iter, st.fast ? lock_first : 4'h0, step2);
    end
  end

  // ****************************************
  // decode hold
  // ****************************************
  assign xfer_ok   = (st.cmp_cnt <= 3'h1) && !(st.iss_valid && st.iss_op == FHI_OP_CMP);
  assign dec_ready = ce && (!st.iss_valid || issue_fire)
                   && !(dec_op == FHI_OP_XFER && !xfer_ok);
  assign setup     = psel && !penable;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.cc_valid = 1'b0;
    if (issue_fire) begin
      next_st.iss_valid = 1'b0;
    end
    if (dec_valid && dec_ready) begin
      next_st.iss_valid = 1'b1;
      next_st.iss_op    = fhi_op_t'(dec_op);
      next_st.iss_dst   = dec_dst;
      next_st.iss_a     = dec_src_a;
      next_st.iss_b     = dec_src_b;
      next_st.iss_cnt   = dec_count;
      next_st.iss_dp    = dec_dp;
    end
    // compare and status transfer
    if (st.cmp_cnt != 3'h0) begin
      next_st.cmp_cnt = st.cmp_cnt - 3'h1;
    end
    if (st.cmp_cnt == 3'h1) begin
      next_st.fp_status_control_reg_cc = cmp_result;
    end
    if (issue_fire && st.iss_op == FHI_OP_CMP) begin
      next_st.cmp_cnt = FHI_CMP_CC_LAT;
    end
    if (issue_fire && st.iss_op == FHI_OP_XFER) begin
      next_st.cc_valid = 1'b1;
      next_st.cc_out   = st.fp_status_control_reg_cc;
    end
    // load multiple sequence
    case (st.ldm_st)
      FHI_LDM_IDLE: begin
        if (issue_fire && st.iss_op == FHI_OP_LDM) begin
          next_st.ldm_st   = FHI_LDM_PIPE;
          next_st.ldm_cnt  = FHI_LDM_WR_LAT - 3'h1;
          next_st.ldm_next = st.iss_dst;
          next_st.ldm_left = st.iss_cnt;
        end
      end
      FHI_LDM_PIPE: begin
        next_st.ldm_cnt = st.ldm_cnt - 3'h1;
        if (st.ldm_cnt == 3'h1) begin
          next_st.ldm_st = FHI_LDM_WRITE;
        end
      end
      FHI_LDM_WRITE: begin
        next_st.ldm_next = st.ldm_next + 5'(FHI_LDM_PER_W);
        next_st.ldm_left = (st.ldm_left > FHI_LDM_PER_W) ? st.ldm_left - FHI_LDM_PER_W : 6'h0;
        if (st.ldm_left <= FHI_LDM_PER_W) begin
          next_st.ldm_st = FHI_LDM_IDLE;
        end
      end
      default: begin
        next_st.ldm_st = FHI_LDM_IDLE;
      end
    endcase
    // arithmetic writeback
    if (st.ar_busy) begin
      next_st.ar_cnt = st.ar_cnt - 5'h1;
      if (st.ar_cnt == 5'h1) begin
        next_st.ar_busy = 1'b0;
      end
    end
    if (issue_fire && is_arith) begin
      next_st.ar_busy = 1'b1;
      next_st.ar_cnt  = FHI_ARITH_WB + {1'b0, n_iter} - 5'h1;
      next_st.ar_dst  = st.iss_dst;
      next_st.ar_n    = n_iter;
    end
    // source release walk
    if (st.vs_active) begin
      next_st.vs_cnt = st.vs_cnt + 4'h1;
      if (vs_iter + 4'h1 >= st.vs_n && st.vs_cnt >= {2'b00, st.vs_off}) begin
        next_st.vs_active = 1'b0;
      end
    end
    if (issue_fire && lock_src) begin
      next_st.vs_active = 1'b1;
      next_st.vs_a      = st.iss_a;
      next_st.vs_b      = st.iss_b;
      next_st.vs_step2  = step2;
      next_st.vs_n      = n_iter;
      next_st.vs_first  = st.fast ? lock_first : 4'h0;
      next_st.vs_off    = (st.fast && !st.iss_dp) ? FHI_CLR_OFF_TWO : FHI_CLR_OFF_ONE;
      next_st.vs_cnt    = 4'h1;
    end
    // apb
    if (setup) begin
      next_st.pslverr = 1'b0;
      next_st.prdata  = 32'h0;
      case (paddr)
        FHI_ADDR_CTRL: begin
          next_st.prdata[FHI_CTRL_FAST]                     = st.fast;
          next_st.prdata[FHI_CTRL_LEN_LO +: 3]              = st.len;
          next_st.prdata[FHI_CTRL_STR_LO +: 2]              = st.stride;
        end
        FHI_ADDR_STAT: begin
          next_st.prdata[FHI_STAT_CC_LO +: 4]               = st.fp_status_control_reg_cc;
          next_st.prdata[FHI_STAT_ISS]                      = st.iss_valid;
          next_st.prdata[FHI_STAT_CMP]                      = st.cmp_cnt != 3'h0;
          next_st.prdata[FHI_STAT_LDM]                      = st.ldm_st != FHI_LDM_IDLE;
          next_st.prdata[FHI_STAT_AR]                       = st.ar_busy;
          next_st.prdata[FHI_STAT_VS]                       = st.vs_active;
        end
        FHI_ADDR_DLOCK: next_st.prdata = sbi.dst_lock;
        FHI_ADDR_SLOCK: next_st.prdata = sbi.src_lock;
        default:        next_st.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && pwrite && paddr == FHI_ADDR_CTRL) begin
      next_st.fast   = pwdata[FHI_CTRL_FAST];
      next_st.len    = pwdata[FHI_CTRL_LEN_LO +: 3];
      next_st.stride = pwdata[FHI_CTRL_STR_LO +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.fast   <= FHI_FAST_RST;
      st.len    <= FHI_LEN_RST;
      st.stride <= FHI_STRIDE_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign prdata   = st.prdata;
  assign pready   = 1'b1;
  assign pslverr  = st.pslverr & psel & penable;
  assign cc_valid = st.cc_valid;
  assign cc_out   = st.cc_out;

  // ****************************************
  // checks
  // ****************************************
  sequence cmp_go_s;
    issue_fire && st.iss_op == FHI_OP_CMP;
  endsequence
  sequence xfer_wait_s;
    (!xfer_ok)[*3] ##1 xfer_ok;
  endsequence

  xfer_hold_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    cmp_go_s |=> xfer_wait_s) else $error("status transfer released early");
  cc_deliver_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    issue_fire && st.iss_op == FHI_OP_XFER |=> cc_valid && cc_out == $past(st.fp_status_control_reg_cc))
    else $error("condition codes not delivered");
  ldm_write_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    issue_fire && st.iss_op == FHI_OP_LDM && st.iss_cnt != 6'h0
    |-> ##4 st.ldm_st == FHI_LDM_WRITE) else $error("load write not at fourth cycle");
  part_fwd_a: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_hit |-> (st.ldm_st == FHI_LDM_WRITE || st.ar_cnt == 5'h1))
    else $error("forward without a write");
  len_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
    st.len == 3'b011 |-> n_iter == 4'h4) else $error("length decode wrong");
  stride_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
    st.stride == 2'b00 |-> !step2) else $error("stride decode wrong");
  mul_wb_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    issue_fire && is_arith && n_iter == 4'h1 |-> ##8 (sbi.clr_dst != 32'h0))
    else $error("arith result not written in time");
  war_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    st.iss_valid && |(dst_need & sbi.src_lock) |-> !issue_fire)
    else $error("load passed a source lock");
  fast_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    st.fast && issue_fire && !(st.iss_op inside {FHI_OP_MUL, FHI_OP_MAC}) |-> sbi.set_src == 32'h0)
    else $error("fast mode locked non multiply");
  fast_dp_a: assert property (@(posedge pclk) disable iff (!presetn)
    st.fast && issue_fire && st.iss_dp && n_iter <= FHI_FAST_DP_THR |-> sbi.set_src == 32'h0)
    else $error("fast double locked short vector");
  fast_scalar_a: assert property (@(posedge pclk) disable iff (!presetn)
    st.fast && issue_fire && n_iter == 4'h1 |-> sbi.set_src == 32'h0)
    else $error("fast scalar locked sources");
  full_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st.fast && issue_fire && is_arith && !st.vs_active |-> (sbi.set_src & src_need) == src_need)
    else $error("full mode missed a source lock");

endmodule

// File: fhi_core_model.sv
`timescale 1ns/1ps
module fhi_core_model
  import fhi_pkg::*;
(
  // clock
  input  wire logic       pclk,
  // decode to interlock
  output logic            dec_valid,
  output logic     [2:0]  dec_op,
  output logic     [4:0]  dec_dst,
  output logic     [4:0]  dec_src_a,
  output logic     [4:0]  dec_src_b,
  output logic     [5:0]  dec_count,
  output logic            dec_dp,
  output logic     [3:0]  cmp_result,
  // status from interlock
  input  wire logic       dec_ready,
  input  wire logic       issue_fire,
  input  wire logic       fwd_hit,
  input  wire logic       cc_valid,
  input  wire logic [3:0] cc_out
);
  int         cyc;
  int         nfire;
  int         f0;
  int         f1;
  int         fwd_cyc;
  int         cc_cyc;
  logic [3:0] cc_val;
  int         timeouts;

  initial begin
    dec_valid  = 1'h0;
    dec_op     = 3'h0;
    dec_dst    = 5'h0;
    dec_src_a  = 5'h0;
    dec_src_b  = 5'h0;
    dec_count  = 6'h0;
    dec_dp     = 1'h0;
    cmp_result = 4'h0;
  end

  // ****************************************
  // issue and delivery monitor
  // ****************************************
  always @(posedge pclk) begin
    cyc++;
    if (issue_fire === 1'b1) begin
      if (nfire == 0) f0 = cyc;
      if (nfire == 1) f1 = cyc;
      nfire++;
    end
    if (fwd_hit === 1'b1) fwd_cyc = cyc;
    if (cc_valid === 1'b1) begin
      cc_cyc = cyc;
      cc_val = cc_out;
    end
  end

  task automatic clr();
    nfire   = 0;
    fwd_cyc = -1;
    cc_cyc  = -1;
  endtask

  // held until taken at an edge with dec_ready high
  task automatic send(input logic [21:0] i, input logic dp);
    int k;
    dec_valid <= 1'h1;
    dec_op    <= i[21:19];
    dec_dst   <= i[18:14];
    dec_src_a <= i[13:9];
    dec_src_b <= i[8:4];
    dec_count <= {2'h0, i[3:0]};
    dec_dp    <= dp;
    if (i[21:19] == FHI_OP_CMP) cmp_result <= {i[10:9], i[5:4]};
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (dec_ready !== 1'b1 && k < 100);
    if (k >= 100) timeouts++;
  endtask

  // released fields other than dec_dp and cmp_result show no stale value
  task automatic idle();
    dec_valid <= 1'h0;
    dec_op    <= ~dec_op;
    dec_dst   <= ~dec_dst;
    dec_src_a <= ~dec_src_a;
    dec_src_b <= ~dec_src_b;
    dec_count <= ~dec_count;
  endtask
endmodule

// File: tb_fpu_hazard_interlock.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module tb_fpu_hazard_interlock
  import fhi_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        dec_valid;
  logic [2:0]  dec_op;
  logic [4:0]  dec_dst;
  logic [4:0]  dec_src_a;
  logic [4:0]  dec_src_b;
  logic [5:0]  dec_count;
  logic        dec_dp;
  logic        dec_ready;
  logic        issue_fire;
  logic        fwd_hit;
  logic [3:0]  cmp_result;
  logic        cc_valid;
  logic [3:0]  cc_out;
  logic [21:0] i1;
  logic [21:0] i2;
  logic [31:0] rd;
  logic        er;
  int          errors;
  int          check_count;
  int          ntest;

  fhi_interlock DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dec_valid(dec_valid), .dec_op(dec_op), .dec_dst(dec_dst),
    .dec_src_a(dec_src_a), .dec_src_b(dec_src_b), .dec_count(dec_count), .dec_dp(dec_dp),
    .dec_ready(dec_ready), .issue_fire(issue_fire), .fwd_hit(fwd_hit),
    .cmp_result(cmp_result), .cc_valid(cc_valid), .cc_out(cc_out));

  fhi_core_model core (.pclk(pclk), .dec_valid(dec_valid), .dec_op(dec_op),
    .dec_dst(dec_dst), .dec_src_a(dec_src_a), .dec_src_b(dec_src_b), .dec_count(dec_count),
    .dec_dp(dec_dp), .cmp_result(cmp_result), .dec_ready(dec_ready),
    .issue_fire(issue_fire), .fwd_hit(fwd_hit), .cc_valid(cc_valid), .cc_out(cc_out));

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [21:0] ins(input logic [2:0] op, input logic [4:0] d,
                                      input logic [4:0] a, input logic [4:0] b,
                                      input logic [3:0] n);
    return {op, d, a, b, n};
  endfunction

  task automatic summarize();
    errors += core.timeouts;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // apb master
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      errors++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  // ****************************************
  // two instructions back to back
  // ****************************************
  task automatic pair(input logic [31:0] ctrl, input logic dp, input int diff, input bit fwd);
    int k;
    apb(1'h1, FHI_ADDR_CTRL, ctrl);
    core.clr();
    core.send(i1, dp);
    core.send(i2, dp);
    core.idle();
    if (core.timeouts > 0) summarize();
    k = 0;
    while (core.nfire < 2 && k < 80) begin
      @(negedge pclk);
      k++;
    end
    if (k >= 80) begin
      errors++;
      summarize();
    end
    repeat (40) @(posedge pclk);
    `CHK(core.f1 - core.f0, diff)
    if (fwd) `CHK(core.fwd_cyc, core.f1)
    if (i1[21:19] == FHI_OP_CMP) begin
      `CHK(core.cc_cyc - core.f0, 6)
      `CHK(core.cc_val, {i1[10:9], i1[5:4]})
    end
    apb(1'h0, FHI_ADDR_DLOCK, 32'h0);
    `CHK(rd, 32'h0)
    ntest++;
    $display("test %0d done", ntest);
  endtask

  initial begin
    presetn = 1'h0;
    ce      = 1'h1;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 12'h0;
    pwdata  = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, FHI_ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'h1, FHI_ADDR_CTRL, 32'hffffffff);
    apb(1'h0, FHI_ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h371)
    apb(1'h0, 12'h010, 32'h0);
    `CHK(er, 1'h1)
    `CHK(rd, 32'h0)
    apb(1'h1, FHI_ADDR_DLOCK, 32'hffffffff);
    `CHK(er, 1'h0)
    apb(1'h0, FHI_ADDR_STAT, 32'h0);
    `CHK(rd, 32'h0)
    // write with clock enable low must not land
    ce <= 1'h0;
    apb(1'h1, FHI_ADDR_CTRL, 32'h0);
    ce <= 1'h1;
    apb(1'h0, FHI_ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h371)
    $display("register test done");
    i1 = ins(FHI_OP_CMP, 5'h0, 5'h1, 5'h2, 4'h0);
    i2 = ins(FHI_OP_XFER, 5'h0, 5'h0, 5'h0, 4'h0);
    pair(32'h0, 1'h0, 5, 0);
    i1 = ins(FHI_OP_LDM, 5'h08, 5'h0, 5'h0, 4'h8);
    i2 = ins(FHI_OP_ADD, 5'h01, 5'h02, 5'h0f, 4'h0);
    pair(32'h0, 1'h0, 7, 1);
    i1 = ins(FHI_OP_LDM, 5'h07, 5'h0, 5'h0, 4'h8);
    i2 = ins(FHI_OP_ADD, 5'h10, 5'h07, 5'h19, 4'h0);
    pair(32'h30, 1'h0, 4, 1);
    i1 = ins(FHI_OP_MUL, 5'h04, 5'h01, 5'h00, 4'h0);
    i2 = ins(FHI_OP_ADD, 5'h05, 5'h04, 5'h03, 4'h0);
    pair(32'h0, 1'h0, 8, 1);
    i1 = ins(FHI_OP_MUL, 5'h08, 5'h10, 5'h18, 4'h0);
    i2 = ins(FHI_OP_LDM, 5'h10, 5'h0, 5'h0, 4'hc);
    pair(32'h30, 1'h0, 5, 0);
    pair(32'h31, 1'h0, 1, 0);
    pair(32'h41, 1'h0, 3, 0);
    pair(32'h21, 1'h1, 2, 0);
    pair(32'h11, 1'h1, 1, 0);
    pair(32'h01, 1'h0, 1, 0);
    i1 = ins(FHI_OP_MAC, 5'h08, 5'h10, 5'h18, 4'h0);
    pair(32'h31, 1'h0, 1, 0);
    // load of one odd register: stride one locks it, stride two would not
    i2 = ins(FHI_OP_LDM, 5'h11, 5'h0, 5'h0, 4'h1);
    pair(32'h30, 1'h0, 3, 0);
    summarize();
  end
endmodule
